// file: ldo_short_circuit_protect.sv
// Short-circuit guard for five regulators, with register port.
// Assumes detector pins are asynchronous and standby event is synchronous.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
module ldo_short_circuit_protect #(
   parameter int DEBOUNCE_CYCLES = ldo_scp_pkg::DEBOUNCE_CYC
) (
   input  wire logic                            i_clk,
   input  wire logic                            i_rst,
   input  wire logic [ldo_scp_pkg::ADDR_W-1:0]  i_addr,
   input  wire logic [ldo_scp_pkg::DATA_W-1:0]  i_wdata,
   input  wire logic                            i_wr,
   input  wire logic                            i_rd,
   output logic      [ldo_scp_pkg::DATA_W-1:0]  o_rdata,
   input  wire logic [4:0]                      i_overcurrent,
   input  wire logic                            i_standby_event,
   output logic      [4:0]                      o_regulator_active,
   output logic      [1:0]                      o_pll_supply_level_sel,
   output logic                                 o_irq
);

   // ************************************************************
   // State
   // ************************************************************
   logic [4:0]                     regulator_on_bit_reg;
   logic [4:0]                     regulator_on_bit_next;
   logic [4:0]                     standby_gate_bit_reg;
   logic                           short_protect_global_on_reg;
   logic                           short_fault_mask_reg;
   logic                           short_fault_flag_reg;
   logic                           short_fault_flag_next;
   ldo_scp_pkg::pll_level_t        pll_supply_level_sel_reg;
   logic [4:0]                     fault_level;
   logic [4:0]                     fault_prev_reg;
   logic [4:0]                     fault_trip;
   logic [4:0]                     fault_seen;
   logic [ldo_scp_pkg::DATA_W-1:0] rdata_next;
   logic                           wr_enable;
   logic                           wr_standby;
   logic                           wr_control;
   logic                           wr_flag;
   logic                           wr_pll;
   logic                           flag_clear;

   // ************************************************************
   // Address decode
   // ************************************************************
   // One compare shared by every write decode, so all stay consistent
   function automatic logic hit(input logic                           strobe,
                                input logic [ldo_scp_pkg::ADDR_W-1:0] addr,
                                input logic [ldo_scp_pkg::ADDR_W-1:0] target);
      return strobe && (addr == target);
   endfunction

   // Write strobes per register
   assign wr_enable  = hit(i_wr, i_addr, ldo_scp_pkg::REG_ENABLE);
   assign wr_standby = hit(i_wr, i_addr, ldo_scp_pkg::REG_STANDBY);
   assign wr_control = hit(i_wr, i_addr, ldo_scp_pkg::REG_CONTROL);
   assign wr_flag    = hit(i_wr, i_addr, ldo_scp_pkg::REG_FLAG);
   assign wr_pll     = hit(i_wr, i_addr, ldo_scp_pkg::REG_PLL_SEL);
   assign flag_clear = wr_flag && i_wdata[ldo_scp_pkg::FLAG_BIT];

   // ************************************************************
   // Detector filters, one per guarded regulator
   // ************************************************************
   // Only five detectors exist; the other regulators are not guarded
   for (genvar g = 0; g < ldo_scp_pkg::NUM_GUARDED; g++) begin : g_deb
      ocp_debounce #(
         .CYCLES   (DEBOUNCE_CYCLES)
      ) u_deb (
         .i_clk    (i_clk),
         .i_rst    (i_rst),
         .i_raw    (i_overcurrent[g]),
         .o_stable (fault_level[g])
      );
   end

   // ************************************************************
   // Fault handling
   // ************************************************************
   // Act on the rising edge of a confirmed fault, so a later re-enable by
   // software is not instantly undone while the short persists
   assign fault_trip = fault_level & ~fault_prev_reg;
   assign fault_seen = short_protect_global_on_reg ? (fault_trip & regulator_on_bit_reg)
                                                   : 5'h00;

   // Software write first, hardware shutdown wins over it
   always_comb begin
      regulator_on_bit_next = regulator_on_bit_reg;
      if (wr_enable) begin
         regulator_on_bit_next = i_wdata[4:0];
      end
      regulator_on_bit_next = regulator_on_bit_next & ~fault_seen;
   end

   // Flag: set beats write-one-to-clear in the same cycle
   always_comb begin
      short_fault_flag_next = short_fault_flag_reg;
      if (flag_clear) begin
         short_fault_flag_next = 1'b0;
      end
      if (|fault_seen) begin
         short_fault_flag_next = 1'b1;
      end
   end

   // Enable and flag registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         regulator_on_bit_reg <= ldo_scp_pkg::ENABLE_RESET;
         short_fault_flag_reg <= 1'b0;
         fault_prev_reg       <= 5'h00;
      end else begin
         regulator_on_bit_reg <= regulator_on_bit_next;
         short_fault_flag_reg <= short_fault_flag_next;
         fault_prev_reg       <= fault_level;
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         standby_gate_bit_reg        <= ldo_scp_pkg::STANDBY_RESET;
         short_protect_global_on_reg <= ldo_scp_pkg::GLOBAL_RESET;
         short_fault_mask_reg        <= ldo_scp_pkg::MASK_RESET;
         pll_supply_level_sel_reg    <= ldo_scp_pkg::PLL_SEL_RESET;
      end else begin
         if (wr_standby) begin
            standby_gate_bit_reg <= i_wdata[4:0];
         end
         if (wr_control) begin
            short_protect_global_on_reg <= i_wdata[ldo_scp_pkg::CTRL_GLOBAL_BIT];
            short_fault_mask_reg        <= i_wdata[ldo_scp_pkg::CTRL_MASK_BIT];
         end
         if (wr_pll) begin
            pll_supply_level_sel_reg <= ldo_scp_pkg::pll_level_t'(i_wdata[1:0]);
         end
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   // Reads show programmed bits, and REG_DETECT the debounced detector levels; effective state is visible only on pins
   always_comb begin
      rdata_next = '0;
      if (i_rd) begin
         case (i_addr)
            ldo_scp_pkg::REG_ENABLE:  rdata_next = {3'h0, regulator_on_bit_reg};
            ldo_scp_pkg::REG_STANDBY: rdata_next = {3'h0, standby_gate_bit_reg};
            ldo_scp_pkg::REG_CONTROL: rdata_next = {6'h00, short_fault_mask_reg,
                                                    short_protect_global_on_reg};
            ldo_scp_pkg::REG_FLAG:    rdata_next = {7'h00, short_fault_flag_reg};
            ldo_scp_pkg::REG_PLL_SEL: rdata_next = {6'h00, pll_supply_level_sel_reg};
            ldo_scp_pkg::REG_DETECT:  rdata_next = {3'h0, fault_level};
            default:                  rdata_next = '0;
         endcase
      end
   end

   // Read data valid the cycle after the strobe only
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= rdata_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Standby with gate bit set switches the regulator off
   assign o_regulator_active     = regulator_on_bit_reg
                                   & ~(standby_gate_bit_reg & {5{i_standby_event}});
   assign o_pll_supply_level_sel = pll_supply_level_sel_reg;
   assign o_irq                  = short_fault_flag_reg & ~short_fault_mask_reg;

   // ************************************************************
   // Checks
   // ************************************************************
   property p_trip_clears;
      @(posedge i_clk) disable iff (i_rst)
      (short_protect_global_on_reg && fault_trip[0] && regulator_on_bit_reg[0])
         |=> (!regulator_on_bit_reg[0] && short_fault_flag_reg);
   endproperty
   a_trip_clears: assert property (p_trip_clears) else $error("fault did not shut down");

   property p_flag_same;
      @(posedge i_clk) disable iff (i_rst)
      ($fell(regulator_on_bit_reg[1]) && !$past(i_wr)) |-> short_fault_flag_reg;
   endproperty
   a_flag_same: assert property (p_flag_same) else $error("flag missing at shutdown");

   property p_mask;
      @(posedge i_clk) disable iff (i_rst)
      short_fault_mask_reg |-> !o_irq;
   endproperty
   a_mask: assert property (p_mask) else $error("masked flag reached irq");

   property p_irq_unmasked;
      @(posedge i_clk) disable iff (i_rst)
      (short_fault_flag_reg && !short_fault_mask_reg) |-> o_irq;
   endproperty
   a_irq_unmasked: assert property (p_irq_unmasked) else $error("irq not raised");

   property p_off_no_act;
      @(posedge i_clk) disable iff (i_rst)
      (!short_protect_global_on_reg && !i_wr) |=> $stable(regulator_on_bit_reg)
                                                   && !$rose(short_fault_flag_reg);
   endproperty
   a_off_no_act: assert property (p_off_no_act) else $error("acted while disabled");

   property p_flag_sticky;
      @(posedge i_clk) disable iff (i_rst)
      (short_fault_flag_reg && !i_wr) |=> short_fault_flag_reg;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped alone");

   property p_standby_off;
      @(posedge i_clk) disable iff (i_rst)
      (i_standby_event && standby_gate_bit_reg[2]) |-> !o_regulator_active[2];
   endproperty
   a_standby_off: assert property (p_standby_off) else $error("standby did not gate");

   property p_read_prog;
      @(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == ldo_scp_pkg::REG_ENABLE)
         |=> (o_rdata[4:0] == $past(regulator_on_bit_reg));
   endproperty
   a_read_prog: assert property (p_read_prog) else $error("read not programmed value");

   property p_trip_any;
      @(posedge i_clk) disable iff (i_rst)
      (short_protect_global_on_reg && |(fault_trip & regulator_on_bit_reg))
         |=> ((regulator_on_bit_reg & $past(fault_trip)) == 5'h00);
   endproperty
   a_trip_any: assert property (p_trip_any) else $error("tripped regulator left on");

   property p_flag_on_trip;
      @(posedge i_clk) disable iff (i_rst)
      (short_protect_global_on_reg && |(fault_trip & regulator_on_bit_reg))
         |=> short_fault_flag_reg;
   endproperty
   a_flag_on_trip: assert property (p_flag_on_trip) else $error("trip without flag");

   property p_no_drop;
      @(posedge i_clk) disable iff (i_rst)
      (!wr_enable && fault_seen == 5'h00) |=> $stable(regulator_on_bit_reg);
   endproperty
   a_no_drop: assert property (p_no_drop) else $error("enable changed with no cause");

   property p_enable_write;
      @(posedge i_clk) disable iff (i_rst)
      (wr_enable && fault_seen == 5'h00)
         |=> ({3'h0, regulator_on_bit_reg} == ($past(i_wdata) & 8'h1F));
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write lost");

   property p_flag_clear;
      @(posedge i_clk) disable iff (i_rst)
      (flag_clear && fault_seen == 5'h00) |=> !short_fault_flag_reg;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag clear lost");

   property p_global_write;
      @(posedge i_clk) disable iff (i_rst)
      wr_control
         |=> (short_protect_global_on_reg == $past(i_wdata[ldo_scp_pkg::CTRL_GLOBAL_BIT]));
   endproperty
   a_global_write: assert property (p_global_write) else $error("global bit not taken");

   property p_mask_write;
      @(posedge i_clk) disable iff (i_rst)
      wr_control
         |=> (short_fault_mask_reg == $past(i_wdata[ldo_scp_pkg::CTRL_MASK_BIT]));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask bit not taken");

   property p_pll_write;
      @(posedge i_clk) disable iff (i_rst)
      wr_pll |=> ({6'h00, o_pll_supply_level_sel} == ($past(i_wdata) & 8'h03));
   endproperty
   a_pll_write: assert property (p_pll_write) else $error("pll select not taken");

   property p_awake_follows;
      @(posedge i_clk) disable iff (i_rst)
      !i_standby_event |-> (o_regulator_active == regulator_on_bit_reg);
   endproperty
   a_awake_follows: assert property (p_awake_follows) else $error("active differs awake");

   property p_off_when_clear;
      @(posedge i_clk) disable iff (i_rst)
      ((o_regulator_active & ~regulator_on_bit_reg) == 5'h00);
   endproperty
   a_off_when_clear: assert property (p_off_when_clear) else $error("disabled but active");

   property p_rdata_idle;
      @(posedge i_clk) disable iff (i_rst)
      !i_rd |=> (o_rdata == 8'h00);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside window");

endmodule

// file: ldo_scp_pkg.sv
// Constants, register map and types for the regulator short-circuit guard.
// Assumes a single 125 MHz clock and a plain strobe register port.
// Contract
// - Debounce each over-current detector before treating it as a fault.
// - Exactly five regulators have detector inputs and protection.
// - Confirmed fault with protection on clears that regulator's enable bit.
// - Fault flag sets in the same cycle the enable bit clears.
// - Mask bit keeps the fault flag off the interrupt output.
// - One global software bit enables the whole protection function.
// - With global enable clear, faults neither flag nor disable regulators.
// - Global protection enable resets to zero.
// - PLL supply select codes 00..11 mean 1.2, 1.25, 1.50, 1.8 volts.
// - Regulator is off when enable clear, or standby gate and standby event.
// - Register reads return programmed bits, not the effective state; REG_DETECT reads return the debounced detector levels.
package ldo_scp_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam int         ADDR_W          = 4;
   localparam int         DATA_W          = 8;
   localparam int         NUM_GUARDED     = 5;
   localparam logic [3:0] REG_ENABLE      = 4'h0;
   localparam logic [3:0] REG_STANDBY     = 4'h1;
   localparam logic [3:0] REG_CONTROL     = 4'h2;
   localparam logic [3:0] REG_FLAG        = 4'h3;
   localparam logic [3:0] REG_PLL_SEL     = 4'h4;
   localparam logic [3:0] REG_DETECT      = 4'h5;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int         CTRL_GLOBAL_BIT = 0;
   localparam int         CTRL_MASK_BIT   = 1;
   localparam int         FLAG_BIT        = 0;
   localparam logic [4:0] ENABLE_RESET    = 5'h00;
   localparam logic [4:0] STANDBY_RESET   = 5'h00;
   localparam logic       GLOBAL_RESET    = 1'b0;
   localparam logic       MASK_RESET      = 1'b0;

   // ************************************************************
   // Debounce timing
   // ************************************************************
   localparam int         CLK_MHZ         = 125;
   localparam int         DEBOUNCE_US     = 30;
   localparam int         DEBOUNCE_CYC    = DEBOUNCE_US * CLK_MHZ;
   localparam int         DEB_CNT_W       = 12;

   // PLL supply level codes
   typedef enum logic [1:0] {
      PLL_1V20 = 2'b00,
      PLL_1V25 = 2'b01,
      PLL_1V50 = 2'b10,
      PLL_1V80 = 2'b11
   } pll_level_t;
   localparam pll_level_t PLL_SEL_RESET   = PLL_1V20;

endpackage

// file: ocp_debounce.sv
// Debouncer for one over-current detector pin.
// Assumes an asynchronous pin; it is synchronised here before use.
`timescale 1ns/1ps
module ocp_debounce #(
   parameter int CYCLES = ldo_scp_pkg::DEBOUNCE_CYC
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_raw,
   output logic      o_stable
);

   // ************************************************************
   // Synchroniser and steady-level counter
   // ************************************************************
   logic                                sync1_reg;
   logic                                sync2_reg;
   logic [ldo_scp_pkg::DEB_CNT_W-1:0] cnt_reg;
   logic [ldo_scp_pkg::DEB_CNT_W-1:0] cnt_next;
   logic                                stable_next;
   logic                                differs;
   localparam int                                CNT_W = ldo_scp_pkg::DEB_CNT_W;
   localparam logic [CNT_W-1:0]                  LAST  = CNT_W'(CYCLES - 1);

   // Level must differ for a full window before it is taken
   assign differs     = sync2_reg != o_stable;
   assign cnt_next    = (!differs || cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
   assign stable_next = (differs && cnt_reg == LAST) ? sync2_reg : o_stable;

   // Two flops, then the filter
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         cnt_reg   <= '0;
         o_stable  <= 1'b0;
      end else begin
         sync1_reg <= i_raw;
         sync2_reg <= sync1_reg;
         cnt_reg   <= cnt_next;
         o_stable  <= stable_next;
      end
   end

   // Glitch shorter than the window never reaches the output
   property p_deb_hold;
      @(posedge i_clk) disable iff (i_rst)
      (cnt_reg != LAST) |=> $stable(o_stable);
   endproperty
   a_deb_hold: assert property (p_deb_hold) else $error("debounce output moved early");

endmodule

// file: ocp_source.sv
// Model of the five over-current detector comparators.
// Assumes the bench sets lines and bounce by hierarchical access.
`timescale 1ns/1ps
module ocp_source (
   input  wire logic       i_clk,
   output logic      [4:0] o_pins
);
   // ************
   // Detector pins
   // ************
   logic [4:0] lines  = 5'h00;
   logic       bounce = 1'b0;
   logic       tgl    = 1'b0;
   // Bounce toggles every cycle, never steady long enough to pass
   initial o_pins = 5'h00;
   always @(posedge i_clk) begin
      tgl    <= ~tgl;
      o_pins <= lines & {5{~bounce | tgl}};
   end
endmodule

// file: test_ldo_short_circuit_protect.sv
// Self-checking bench for the regulator short-circuit guard.
// Assumes the debounce count is cut to 4 cycles for simulation.
`timescale 1ns/1ps
module test_ldo_short_circuit_protect;
   // ************
   // Signals
   // ************
   logic       i_clk = 1'b0;
   logic       i_rst = 1'b1;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00;
   logic       i_wr = 1'b0;
   logic       i_rd = 1'b0;
   logic [7:0] o_rdata;
   logic [4:0] pins;
   logic       i_standby_event = 1'b0;
   logic [4:0] o_regulator_active;
   logic [1:0] o_pll_supply_level_sel;
   logic       o_irq;
   int         num_errors = 0;
   int         n_tests = 0;
   int         seed = 32'h189C;
   logic [7:0] d;
   logic [4:0] en, gt;
   logic       ev;
   initial forever #4 i_clk = ~i_clk;
   ldo_short_circuit_protect #(.DEBOUNCE_CYCLES(4)) ldo_short_circuit_protect_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_overcurrent(pins),
      .i_standby_event(i_standby_event), .o_regulator_active(o_regulator_active),
      .o_pll_supply_level_sel(o_pll_supply_level_sel), .o_irq(o_irq));
   ocp_source ocp_source_inst (.i_clk(i_clk), .o_pins(pins));
   // ************
   // Helpers
   // ************
   // Effective state: off when disabled or gated by standby
   function automatic logic [7:0] exp_on(logic [4:0] e, logic [4:0] g, logic s);
      return {3'h0, e & ~(g & {5{s}})};
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge i_clk);
      i_rd <= 1'b1; i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   // Bounded wait for the guarded regulator to drop
   task automatic wait_drop(input int n);
      for (int i = 0; i < 40; i++) begin
         @(posedge i_clk);
         #1;
         if (o_regulator_active[n] === 1'b0) return;
      end
      num_errors++;
      stop_test();
   endtask
   // ************
   // Main sequence
   // ************
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int a = 0; a < 6; a++) begin
         rd(a[3:0], d);
         chk(d, 8'h00);
      end
      rd(4'hF, d);
      chk(d, 8'h00);
      $display("reset values done");
      for (int k = 0; k < 4; k++) begin
         wr(ldo_scp_pkg::REG_PLL_SEL, k[7:0]);
         chk({6'h00, o_pll_supply_level_sel}, k[7:0]);
         rd(ldo_scp_pkg::REG_PLL_SEL, d);
         chk(d, k[7:0]);
      end
      $display("pll select done");
      for (int k = 0; k < 6; k++) begin
         en = 5'($random(seed));
         gt = 5'($random(seed));
         ev = k[0];
         wr(ldo_scp_pkg::REG_ENABLE, {3'h0, en});
         wr(ldo_scp_pkg::REG_STANDBY, {3'h0, gt});
         @(posedge i_clk);
         i_standby_event <= ev;
         @(posedge i_clk);
         #1 chk({3'h0, o_regulator_active}, exp_on(en, gt, ev));
         rd(ldo_scp_pkg::REG_ENABLE, d);
         chk(d, {3'h0, en});
      end
      @(posedge i_clk);
      i_standby_event <= 1'b0;
      wr(ldo_scp_pkg::REG_STANDBY, 8'h00);
      $display("standby done");
      // Protection off: fault is seen but acts on nothing
      wr(ldo_scp_pkg::REG_ENABLE, 8'h1F);
      ocp_source_inst.lines <= 5'h01;
      repeat (12) @(posedge i_clk);
      rd(ldo_scp_pkg::REG_DETECT, d);
      chk(d, 8'h01);
      chk({3'h0, o_regulator_active}, 8'h1F);
      chk({7'h00, o_irq}, 8'h00);
      ocp_source_inst.lines <= 5'h00;
      wr(ldo_scp_pkg::REG_CONTROL, 8'h01);
      // Bouncing detectors must never pass the debouncer
      ocp_source_inst.bounce <= 1'b1;
      ocp_source_inst.lines <= 5'h1F;
      repeat (20) @(posedge i_clk);
      #1 chk({3'h0, o_regulator_active}, 8'h1F);
      ocp_source_inst.lines <= 5'h00;
      ocp_source_inst.bounce <= 1'b0;
      repeat (10) @(posedge i_clk);
      $display("no-shutdown cases done");
      for (int n = 0; n < 5; n++) begin
         wr(ldo_scp_pkg::REG_ENABLE, 8'h1F);
         ocp_source_inst.lines <= 5'h01 << n;
         wait_drop(n);
         chk({3'h0, o_regulator_active}, 8'h1F & ~(8'h01 << n));
         chk({7'h00, o_irq}, 8'h01);
         rd(ldo_scp_pkg::REG_ENABLE, d);
         chk(d, 8'h1F & ~(8'h01 << n));
         ocp_source_inst.lines <= 5'h00;
         repeat (10) @(posedge i_clk);
         wr(ldo_scp_pkg::REG_CONTROL, 8'h03);
         chk({7'h00, o_irq}, 8'h00);
         rd(ldo_scp_pkg::REG_FLAG, d);
         chk(d, 8'h01);
         @(posedge i_clk);
         #1 chk(o_rdata, 8'h00);
         wr(ldo_scp_pkg::REG_CONTROL, 8'h01);
         chk({7'h00, o_irq}, 8'h01);
         wr(ldo_scp_pkg::REG_FLAG, 8'h01);
         chk({7'h00, o_irq}, 8'h00);
      end
      wr(ldo_scp_pkg::REG_ENABLE, 8'h1F);
      chk({3'h0, o_regulator_active}, 8'h1F);
      $display("shutdown cases done");
      stop_test();
   end
endmodule
